/* File: rtl/external_trigger_handshake.sv */
`timescale 1ns/1ns
`default_nettype none
module external_trigger_handshake
  import ext_trig_pkg::*;
#(
  parameter int PULSE_CYCLES = ext_trig_pkg::PULSE_CYC,
  parameter int MEAS_CYCLES = ext_trig_pkg::MEAS_CYC,
  parameter int DEPTH = ext_trig_pkg::BUF_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clkEn,
  // Front panel keys, pins (asynchronous)
  input wire logic external_mode_key,
  input wire logic manualTrigKey,
  // Trigger link line 2 and shared digital I/O pin
  input wire logic linkTrigInLine,
  input wire logic interlockIn,
  // Configuration
  input wire logic srcExternal,
  input wire logic [ext_trig_pkg::CNT_W-1:0] pulseWidthCfg,
  // Measurement data
  input wire logic [ext_trig_pkg::RDG_W-1:0] adcReading,
  // Indicator and display
  output logic trigIndicator,
  output logic waitDisplay,
  output logic extModeActive,
  // Trigger link line 1
  output logic measure_complete_pulse,
  // Reading buffer
  output logic [ext_trig_pkg::RDG_W-1:0] lastReading,
  output logic [ext_trig_pkg::CNT_W-1:0] readingCount
);
  import ext_trig_pkg::*;

  ////////////////////////////////////////////////////////////////
  logic trigFall;
  logic modeFall;
  logic manFall;
  logic lockMeta_q, lock_q;
  trig_state_t state_q;
  logic extMode_q;
  logic [CNT_W-1:0] cnt_q;
  logic [RDG_W-1:0] buf_q [DEPTH];
  logic [$clog2(DEPTH)-1:0] wrIdx_q;
  logic [RDG_W-1:0] last_q;
  logic [CNT_W-1:0] rdCnt_q;
  logic pulse_q;
  logic accept;
  logic pulseEnd;

  // Last cycle of the completion pulse; zero width selects the default
  function automatic logic pulseDone(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] cfg);
    logic [CNT_W-1:0] width;
    width = (cfg != '0) ? cfg : CNT_W'(PULSE_CYCLES);
    return (cnt + 1'b1) >= width;
  endfunction

  // Link line has its own synchroniser; the digital I/O pin is synchronised separately
  sync_fall_edge u_trig (.sys_clk(sys_clk), .srst(srst), .clkEn(clkEn),
    .lineIn(linkTrigInLine), .levelOut(), .fallPulse(trigFall));
  // Keys are active low presses
  sync_fall_edge u_mode (.sys_clk(sys_clk), .srst(srst), .clkEn(clkEn),
    .lineIn(external_mode_key), .levelOut(), .fallPulse(modeFall));
  sync_fall_edge u_man (.sys_clk(sys_clk), .srst(srst), .clkEn(clkEn),
    .lineIn(manualTrigKey), .levelOut(), .fallPulse(manFall));

  // Interlock: floating pin pulled high externally
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lockMeta_q <= 1'b1;
      lock_q <= 1'b1;
    end else if (clkEn) begin
      lockMeta_q <= interlockIn;
      lock_q <= lockMeta_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Link falling edge with external source and interlock open, or a manual key press
  assign accept = (trigFall & srcExternal & lock_q) | manFall;
  assign pulseEnd = pulseDone(cnt_q, pulseWidthCfg);

  // Mode toggle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      extMode_q <= 1'b0;
    end else if (clkEn && modeFall) begin
      extMode_q <= ~extMode_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= StIdle;
      cnt_q <= CNT_RESET;
    end else if (clkEn) begin
      case (state_q)
        StIdle: begin
          if (extMode_q) begin
            state_q <= StWait;
          end
        end
        StWait: begin
          if (!extMode_q) begin
            state_q <= StIdle;
          end else if (accept) begin
            state_q <= StMeasure;
            cnt_q <= CNT_RESET;
          end
        end
        StMeasure: begin
          // Edges here are dropped
          if (cnt_q >= CNT_W'(MEAS_CYCLES - 1)) begin
            state_q <= StStore;
            cnt_q <= CNT_RESET;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        StStore: begin
          state_q <= StPulse;
          cnt_q <= CNT_RESET;
        end
        StPulse: begin
          if (pulseEnd) begin
            state_q <= extMode_q ? StWait : StIdle;
            cnt_q <= CNT_RESET;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: begin
          state_q <= StIdle;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Reading buffer, wraps round at its depth
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wrIdx_q <= '0;
    end else if (clkEn && state_q == StStore) begin
      buf_q[wrIdx_q] <= adcReading;
      wrIdx_q <= wrIdx_q + 1'b1;
    end
  end

  // Last reading and reading count
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      last_q <= '0;
      rdCnt_q <= CNT_RESET;
    end else if (clkEn && state_q == StStore) begin
      last_q <= adcReading;
      rdCnt_q <= rdCnt_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Completion pulse on link line 1
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pulse_q <= 1'b0;
    end else if (clkEn) begin
      pulse_q <= (state_q == StStore) || (state_q == StPulse && !pulseEnd);
    end
  end

  // Indicator follows the mode
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      trigIndicator <= 1'b0;
      extModeActive <= 1'b0;
    end else if (clkEn) begin
      trigIndicator <= extMode_q;
      extModeActive <= extMode_q;
    end
  end

  // Waiting display only while in StWait in external mode
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      waitDisplay <= 1'b0;
    end else if (clkEn) begin
      waitDisplay <= extMode_q && (state_q == StWait);
    end
  end

  assign measure_complete_pulse = pulse_q;
  assign lastReading = last_q;
  assign readingCount = rdCnt_q;
endmodule
`default_nettype wire

/* File: rtl/ext_trig_pkg.sv */
`default_nettype none
package ext_trig_pkg;
  localparam int CLK_MHZ = 250;
  // Default completion pulse width
  localparam int PULSE_NS = 40;
  localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
  // Default measurement time stand-in
  localparam int MEAS_CYC = 16;
  localparam int RDG_W = 16;
  localparam int BUF_DEPTH = 16;
  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  typedef enum {StIdle, StWait, StMeasure, StStore, StPulse} trig_state_t;
endpackage
`default_nettype wire

/* File: rtl/sync_fall_edge.sv */
`timescale 1ns/1ns
`default_nettype none
module sync_fall_edge (
  // Clock
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clkEn,
  // Line in and edge out
  input wire logic lineIn,
  output logic levelOut,
  output logic fallPulse
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  // Second stage alone reads the first; edge seen one stage later
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else if (clkEn) begin
      meta_q <= lineIn;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign levelOut = sync_q;
  assign fallPulse = prev_q & ~sync_q;
endmodule
`default_nettype wire

/* File: test/ext_trig_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module ext_trig_chk #(parameter int PULSE_CYCLES = 10) (
  // Watched ports
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [15:0] pulseWidthCfg,
  input wire logic trigIndicator,
  input wire logic waitDisplay,
  input wire logic extModeActive,
  input wire logic measure_complete_pulse,
  input wire logic [15:0] lastReading,
  input wire logic [15:0] readingCount
);
  logic [15:0] hiCnt_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Length of the running completion pulse
  always_ff @(posedge sys_clk) begin
    if (srst || !measure_complete_pulse)
      hiCnt_q <= 16'h0000;
    else
      hiCnt_q <= hiCnt_q + 16'h0001;
  end
  property p_ind; trigIndicator == extModeActive; endproperty
  a_ind: assert property (p_ind) else $error("indicator mismatch");
  property p_wait; waitDisplay |-> extModeActive; endproperty
  a_wait: assert property (p_wait) else $error("wait outside mode");
  property p_step; $changed(readingCount) |-> readingCount == $past(readingCount) + 16'h0001; endproperty
  a_step: assert property (p_step) else $error("count step");
  property p_store; $changed(lastReading) |-> $changed(readingCount); endproperty
  a_store: assert property (p_store) else $error("store uncounted");
  property p_pulse; $changed(readingCount) |-> ##[0:1] measure_complete_pulse; endproperty
  a_pulse: assert property (p_pulse) else $error("no pulse");
  property p_width;
    $fell(measure_complete_pulse) |-> hiCnt_q == (pulseWidthCfg == 16'h0000 ? 16'(PULSE_CYCLES) : pulseWidthCfg);
  endproperty
  a_width: assert property (p_width) else $error("pulse width");
  property p_hold; measure_complete_pulse && $past(measure_complete_pulse) |-> $stable(readingCount); endproperty
  a_hold: assert property (p_hold) else $error("store in pulse");
  property p_gap; $changed(readingCount) |=> $stable(readingCount)[*8]; endproperty
  a_gap: assert property (p_gap) else $error("stores too close");
endmodule
bind external_trigger_handshake ext_trig_chk #(.PULSE_CYCLES(PULSE_CYCLES)) chk (.sys_clk, .srst,
  .pulseWidthCfg, .trigIndicator, .waitDisplay, .extModeActive, .measure_complete_pulse, .lastReading,
  .readingCount);
`default_nettype wire

/* File: test/scanner_model.sv */
`timescale 1ns/1ns
`default_nettype none
module scanner_model #(parameter int CHANNELS = 3, parameter int SETTLE = 5) (
  // Clock and control
  input wire logic sys_clk,
  input wire logic start,
  // Trigger link
  input wire logic measDone,
  output logic chanReady,
  output logic [7:0] closed
);
  initial begin
    chanReady = 1'b1;
    closed = 8'h00;
    forever begin
      @(posedge start);
      for (int c = 0; c < CHANNELS; c++) begin
        repeat (SETTLE) @(posedge sys_clk);
        closed <= closed + 8'h01;
        chanReady <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chanReady <= 1'b1;
        for (int i = 0; i < 99 && measDone !== 1'b1; i++) @(posedge sys_clk);
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic sys_clk, srst, srcExternal, interlockIn, start, trigIndicator, waitDisplay, extModeActive;
  logic measure_complete_pulse, chanReady, clkEn;
  logic [2:0] low_q;
  logic [7:0] closed;
  logic [15:0] pulseWidthCfg, adcReading, lastReading, readingCount;
  int n_mismatch, n_compared;
  external_trigger_handshake #(.PULSE_CYCLES(4)) uut (.sys_clk, .srst, .clkEn,
    .external_mode_key(~low_q[0]), .manualTrigKey(~low_q[1]), .linkTrigInLine(chanReady & ~low_q[2]),
    .interlockIn, .srcExternal, .pulseWidthCfg, .adcReading, .trigIndicator, .waitDisplay,
    .extModeActive, .measure_complete_pulse, .lastReading, .readingCount);
  scanner_model scan (.sys_clk, .start, .measDone(measure_complete_pulse), .chanReady, .closed);
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Falling-edge press on key 0, key 1 or the link line
  task automatic hit(input int k);
    low_q[k] <= 1'b1;
    tick(4);
    low_q[k] <= 1'b0;
    tick(1);
  endtask
  task automatic waitp();
    int i;
    for (i = 0; i < 99 && measure_complete_pulse !== 1'b1; i++) tick(1);
    for (; i < 99 && measure_complete_pulse !== 1'b0; i++) tick(1);
    if (i == 99) begin
      n_mismatch++;
      finish_test();
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    clkEn = 1'b1;
    low_q = 3'b000;
    srcExternal = 1'b0;
    interlockIn = 1'b1;
    start = 1'b0;
    pulseWidthCfg = 16'h0000;
    adcReading = 16'h1234;
    tick(20);
    srst <= 1'b0;
    tick(2);
    chk("mode", 16'(extModeActive), 16'h0000);
    hit(0);
    tick(4);
    chk("indicator", 16'(trigIndicator), 16'h0001);
    chk("waiting", 16'(waitDisplay), 16'h0001);
    hit(1);
    waitp();
    chk("count", readingCount, 16'h0001);
    chk("reading", lastReading, 16'h1234);
    interlockIn <= 1'b0;
    srcExternal <= 1'b1;
    hit(2);
    tick(40);
    chk("count", readingCount, 16'h0001);
    interlockIn <= 1'b1;
    srcExternal <= 1'b0;
    hit(2);
    tick(40);
    chk("count", readingCount, 16'h0001);
    srcExternal <= 1'b1;
    pulseWidthCfg <= 16'h0003;
    adcReading <= 16'h00A5;
    hit(2);
    tick(8);
    hit(2);
    waitp();
    tick(40);
    chk("count", readingCount, 16'h0002);
    chk("reading", lastReading, 16'h00A5);
    start <= 1'b1;
    tick(250);
    chk("count", readingCount, 16'h0005);
    chk("channels", 16'(closed), 16'h0003);
    clkEn <= 1'b0;
    hit(2);
    clkEn <= 1'b1;
    tick(40);
    chk("frozen", readingCount, 16'h0005);
    hit(0);
    tick(4);
    chk("mode", 16'(extModeActive), 16'h0000);
    hit(2);
    tick(40);
    chk("count", readingCount, 16'h0005);
    finish_test();
  end
endmodule
`default_nettype wire
